// File: inc/tew_pkg.sv
// package: constants and types for the trim eeprom byte-write block
package tew_pkg;
    localparam logic [7:0]  ADDR_BATCH     = 8'h60;
    localparam logic [7:0]  ADDR_TEMP      = 8'h62;
    localparam logic [7:0]  ADDR_REF       = 8'h63;
    localparam logic [7:0]  ADDR_DRIVE     = 8'h64;
    localparam logic [7:0]  ADDR_TEST      = 8'h65;
    localparam logic [7:0]  ADDR_XGAIN     = 8'h66;
    localparam logic [7:0]  ADDR_YGAIN     = 8'h67;
    localparam logic [7:0]  ADDR_ZGAIN     = 8'h68;
    localparam logic [7:0]  ADDR_FIRST     = 8'h62;
    localparam logic [7:0]  ADDR_LAST      = 8'h68;
    localparam int          WORDS          = 7;
    localparam logic [4:0]  UNLOCK_KEY     = 5'h15;
    localparam logic [1:0]  MODE_EEPROM    = 2'h2;
    localparam logic [1:0]  MODE_PDOWN     = 2'h3;
    localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h1c;  // arbitrary default
    localparam logic [7:0]  WORD_RESET     = 8'h00;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_ACK        = 4'h8;
    // programming time in microseconds and its cycle count at 10 MHz
    localparam int          PROG_TIME_US   = 5000;
    localparam int          CLK_MHZ        = 10;
    localparam int          PROG_CYCLES    = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        TEW_IDLE  = 3'b000,
        TEW_SLAVE = 3'b001,
        TEW_WADDR = 3'b010,
        TEW_DATA  = 3'b011,
        TEW_DONE  = 3'b100,
        TEW_IGN   = 3'b101
    } tew_state_t;

    typedef struct packed {
        logic [5:0] temp_offset;
        logic [3:0] vref_adj;
        logic [3:0] iref_adj;
        logic [3:0] drive_supply;
        logic [3:0] osc_adj;
    } tew_trim_t;
endpackage : tew_pkg

// File: hw/tew_top.sv
// module: i2c byte-write path and word store of the trim eeprom
`timescale 1ns/1ps
module tew_top #(
    parameter int         PROG_CYCLES_P = tew_pkg::PROG_CYCLES
) (
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe_o,
    input  wire logic [6:0]          slave_addr_i,
    input  wire logic [4:0]          unlock_i,
    input  wire logic [1:0]          mode_i,
    output tew_pkg::tew_trim_t       trim_o,
    output logic [7:0]               addr_counter_o,
    output logic                     prog_busy_o
);
    // pin synchronisers, second stage only is used downstream
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_prev;
    logic       sda_prev;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_meta <= {scl_meta[0], scl_i};
            sda_meta <= {sda_meta[0], sda_i};
            scl_prev <= scl_meta[1];
            sda_prev <= sda_meta[1];
        end
    end

    wire scl_s    = scl_meta[1];
    wire sda_s    = sda_meta[1];
    wire scl_rise = scl_s & ~scl_prev;
    wire scl_fall = ~scl_s & scl_prev;
    // both pins come through the same stages, so data moved just after an scl fall never looks
    // like a start or a stop
    wire start_c  = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_c   = scl_s & scl_prev & ~sda_prev & sda_s;

    // map decode for the write select; the counter wrap in next_map compares against ADDR_LAST itself
    function automatic logic in_map(input logic [7:0] a);
        in_map = (a >= tew_pkg::ADDR_FIRST) && (a <= tew_pkg::ADDR_LAST);
    endfunction : in_map

    function automatic logic [7:0] next_map(input logic [7:0] a);
        next_map = (a >= tew_pkg::ADDR_LAST) ? tew_pkg::ADDR_FIRST : a + 8'h01;
    endfunction : next_map

    tew_pkg::tew_state_t state;
    tew_pkg::tew_state_t next_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] word_addr;
    logic [7:0] data_byte;
    logic       data_held;
    logic       ack_drive;
    logic [7:0] mem [tew_pkg::WORDS];
    logic [7:0] addr_counter;
    logic [31:0] prog_cnt;

    wire byte_done   = scl_fall & (bit_cnt == tew_pkg::BIT_LAST);
    wire ack_done    = scl_fall & (bit_cnt == tew_pkg::BIT_ACK);
    wire [7:0] rx_full = {shift[6:0], sda_s};
    wire addr_match  = (shift[7:1] == slave_addr_i) & ~shift[0];
    // a write needs the key and eeprom mode; outside that mode the reference is not up
    wire write_ok    = (unlock_i == tew_pkg::UNLOCK_KEY)
                     & (mode_i == tew_pkg::MODE_EEPROM);
    wire prog_go     = stop_c & data_held & (state == tew_pkg::TEW_DONE);
    wire word_valid  = in_map(word_addr);
    wire [2:0] word_idx = 3'(word_addr - tew_pkg::ADDR_FIRST);
    wire prog_busy   = (prog_cnt != 32'h0);

    // bit counter and shifter run on scl edges within a transfer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (start_c || stop_c) begin
            // parked one below bit 0: the scl fall that closes a start is not a bit
            bit_cnt <= 4'hf;
        end else begin
            if (scl_rise && bit_cnt <= tew_pkg::BIT_LAST) begin
                shift <= rx_full;
            end
            if (scl_fall) begin
                bit_cnt <= (bit_cnt == tew_pkg::BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
            end
        end
    end

    // transfer sequence; a second data byte is not acknowledged
    always_comb begin
        next_state = state;
        unique case (state)
            tew_pkg::TEW_IDLE:  next_state = state;
            tew_pkg::TEW_SLAVE: if (ack_done) begin
                next_state = tew_pkg::TEW_WADDR;
            end
            tew_pkg::TEW_WADDR: if (ack_done) begin
                next_state = tew_pkg::TEW_DATA;
            end
            tew_pkg::TEW_DATA:  if (ack_done) begin
                next_state = tew_pkg::TEW_DONE;
            end
            tew_pkg::TEW_DONE:  next_state = state;
            tew_pkg::TEW_IGN:   next_state = state;
            default:            next_state = tew_pkg::TEW_IDLE;
        endcase
        if (byte_done && state == tew_pkg::TEW_SLAVE && !addr_match) begin
            next_state = tew_pkg::TEW_IGN;
        end
        if (stop_c) begin
            next_state = tew_pkg::TEW_IDLE;
        end
        // start is applied last, so it wins over a stop and over a foreign address
        if (start_c) begin
            next_state = prog_busy ? tew_pkg::TEW_IGN : tew_pkg::TEW_SLAVE;
        end
    end

    // sequence registers, ack drive from scl fall of bit 7 to the next
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state     <= tew_pkg::TEW_IDLE;
            ack_drive <= 1'b0;
            word_addr <= 8'h00;
            data_byte <= 8'h00;
            data_held <= 1'b0;
        end else begin
            state <= next_state;
            if (start_c || stop_c || ack_done) begin
                ack_drive <= 1'b0;
            end else if (byte_done && state == tew_pkg::TEW_SLAVE) begin
                ack_drive <= addr_match;
            end else if (byte_done && (state == tew_pkg::TEW_WADDR ||
                                       state == tew_pkg::TEW_DATA)) begin
                ack_drive <= 1'b1;
            end
            if (byte_done && state == tew_pkg::TEW_WADDR) begin
                word_addr <= shift;
            end
            if (byte_done && state == tew_pkg::TEW_DATA) begin
                data_byte <= shift;
                data_held <= 1'b1;
            end else if (start_c || stop_c) begin
                data_held <= 1'b0;
            end
        end
    end

    // word store and programming timer; only the addressed word changes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < tew_pkg::WORDS; i++) begin
                mem[i] <= tew_pkg::WORD_RESET;
            end
            prog_cnt     <= 32'h0;
            addr_counter <= tew_pkg::ADDR_FIRST;
        end else begin
            if (prog_go && write_ok && word_valid) begin
                mem[word_idx] <= data_byte;
                addr_counter  <= next_map(word_addr);
                prog_cnt      <= 32'(PROG_CYCLES_P);
            // a start while busy is ignored, so a launch never lands on a running cycle
            end else if (prog_busy) begin
                prog_cnt <= prog_cnt - 32'h1;
            end
        end
    end

    // trim fields wired straight from the stored words
    always_comb begin
        trim_o.temp_offset  = mem[0][5:0];
        trim_o.vref_adj     = mem[1][7:4];
        trim_o.iref_adj     = mem[1][3:0];
        trim_o.drive_supply = mem[2][7:4];
        trim_o.osc_adj      = mem[2][3:0];
    end

    // the line is only released, never driven high; the board pull-up supplies the one
    assign sda_o          = 1'b0;          // open drain: only ever pulls low
    assign sda_oe_o       = ack_drive;
    assign addr_counter_o = addr_counter;
    assign prog_busy_o    = prog_busy;

    // checks
    a_ack_after_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (byte_done && state == tew_pkg::TEW_WADDR && !stop_c && !start_c)
            |=> sda_oe_o)
        else $error("no ack after word address");
    a_prog_starts: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_valid) |=> prog_busy_o)
        else $error("programming did not start on stop");
    a_locked_noprog: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && !write_ok && !prog_busy) |=> !prog_busy_o)
        else $error("write while locked");
    a_unmapped_none: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && !word_valid) |=> $stable(addr_counter_o))
        else $error("unmapped address changed state");
    a_one_data_byte: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state == tew_pkg::TEW_DONE && byte_done) |=> !sda_oe_o)
        else $error("second data byte acknowledged");
    a_counter_wraps: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_addr == tew_pkg::ADDR_LAST)
            |=> addr_counter_o == tew_pkg::ADDR_FIRST)
        else $error("counter did not wrap");
    a_temp_field: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_addr == tew_pkg::ADDR_TEMP)
            |=> trim_o.temp_offset == $past(data_byte[5:0]))
        else $error("temperature trim mismatch");
    a_ref_field: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_addr == tew_pkg::ADDR_REF)
            |=> {trim_o.vref_adj, trim_o.iref_adj} == $past(data_byte))
        else $error("reference trim mismatch");

    // acknowledge handling on the ninth clock of each byte
    a_ack_after_slave: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (byte_done && state == tew_pkg::TEW_SLAVE && addr_match) |=> sda_oe_o)
        else $error("no ack after slave address");
    a_ack_after_data: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (byte_done && state == tew_pkg::TEW_DATA) |=> sda_oe_o)
        else $error("no ack after data byte");
    a_no_ack_foreign: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (byte_done && state == tew_pkg::TEW_SLAVE && !addr_match) |=> !sda_oe_o)
        else $error("foreign address acknowledged");
    a_ack_released: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ack_done |=> !sda_oe_o)
        else $error("ack held past the ninth clock");
    a_ignored_silent: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state == tew_pkg::TEW_IGN) |-> !sda_oe_o)
        else $error("ignored transfer drives the line");

    // data capture and programming launch
    a_data_one_shot: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (state == tew_pkg::TEW_DONE && byte_done) |=> $stable(data_byte))
        else $error("extra byte overwrote the data");
    a_busy_loaded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(prog_busy_o) |-> prog_cnt == 32'(PROG_CYCLES_P))
        else $error("programming time not loaded");
    a_busy_count: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_busy_o && !prog_go)
            |=> prog_cnt == $past(prog_cnt) - 32'h1)
        else $error("programming timer skipped a count");
    a_unmapped_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && !word_valid && !prog_busy) |=> !prog_busy_o)
        else $error("unmapped address started programming");
    a_locked_store: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && !write_ok) |=> $stable(trim_o))
        else $error("locked write changed a trim word");

    // analog trim words change only when their own word is written
    a_temp_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(prog_go && write_ok && word_addr == tew_pkg::ADDR_TEMP)
            |=> $stable(trim_o.temp_offset))
        else $error("temperature trim changed without a write");
    a_ref_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(prog_go && write_ok && word_addr == tew_pkg::ADDR_REF)
            |=> $stable({trim_o.vref_adj, trim_o.iref_adj}))
        else $error("reference trim changed without a write");
    a_drive_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(prog_go && write_ok && word_addr == tew_pkg::ADDR_DRIVE)
            |=> $stable({trim_o.drive_supply, trim_o.osc_adj}))
        else $error("drive trim changed without a write");
    a_drive_field: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_addr == tew_pkg::ADDR_DRIVE)
            |=> {trim_o.drive_supply, trim_o.osc_adj} == $past(data_byte))
        else $error("drive trim mismatch");

    // address counter follows the last completed write only
    a_counter_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !(prog_go && write_ok && word_valid) |=> $stable(addr_counter_o))
        else $error("counter moved without a write");
    a_counter_next: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (prog_go && write_ok && word_valid && word_addr != tew_pkg::ADDR_LAST)
            |=> addr_counter_o == $past(word_addr) + 8'h01)
        else $error("counter not at the following word");
endmodule : tew_top

// File: testbench/tew_host_model.sv
// host i2c master model for the trim eeprom byte-write port
`timescale 1ns/1ps
module tew_host_model #(
    parameter int HALF = 5
) (
    input  wire logic       clk_i,
    input  wire logic       sda_line_i,
    output logic            scl_o,
    output logic            sda_o,
    output logic [4:0]      unlock_o,
    output logic [1:0]      mode_o
);
    // bus idle high, device parked in power-down and locked
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        unlock_o = 5'h00;
        mode_o = tew_pkg::MODE_PDOWN;
    end
    // changes land on the falling edge, away from the sampling edge
    task automatic idle(input int n);
        repeat (n) @(negedge clk_i);
    endtask : idle
    // mode and unlock fields; caller waits out start-up after entering eeprom mode
    task automatic set_fields(input logic [1:0] m, input logic [4:0] u);
        mode_o = m;
        unlock_o = u;
        idle(2);
    endtask : set_fields
    // one scl pulse; line sampled late in the high phase where an ack stands
    task automatic bit_cycle(input logic d, output logic seen);
        sda_o = d;
        idle(HALF);
        scl_o = 1'b1;
        idle(HALF);
        seen = sda_line_i;
        scl_o = 1'b0;
    endtask : bit_cycle
    // start, slave address with write bit low, word address, one data byte, stop
    // x adds a stray fourth byte after the data, which the device must not acknowledge
    task automatic write_word(input logic [6:0] sa, input logic [7:0] wa, input logic [7:0] d,
                              input logic x, output logic [3:0] acks);
        logic [7:0] b [4];
        logic       s;
        b = '{{sa, 1'b0}, wa, d, d};
        acks = 4'h0;
        idle(HALF);
        sda_o = 1'b0;
        idle(HALF);
        scl_o = 1'b0;
        for (int k = 0; k < (x ? 4 : 3); k++) begin
            for (int i = 7; i >= 0; i--) bit_cycle(b[k][i], s);
            bit_cycle(1'b1, s);
            acks[3-k] = ~s;
        end
        sda_o = 1'b0;
        idle(HALF);
        scl_o = 1'b1;
        idle(HALF);
        sda_o = 1'b1;
        idle(HALF);
    endtask : write_word
endmodule : tew_host_model

// File: testbench/trim_eeprom_byte_write_map_bench.sv
// self-checking bench for the trim eeprom byte-write block
`timescale 1ns/1ps
module trim_eeprom_byte_write_map_bench;
    localparam int      PROG = 20;
    logic               clk_i, reset_n_i, scl, sda_h, sda_o, sda_oe_o, sda_line, prog_busy_o;
    logic [4:0]         unlock;
    logic [1:0]         mode;
    logic [6:0]         sa;
    logic [7:0]         addr_counter_o;
    logic [3:0]         acks;
    logic               extra = 1'b0;
    tew_pkg::tew_trim_t trim_o;
    int                 n_errors = 0;
    int                 checked = 0;
    int                 exp_cnt = 'h62;
    int                 mem [int];
    // open-drain data line with its pull-up
    assign sda_line = sda_h & ~sda_oe_o;
    tew_top #(.PROG_CYCLES_P(PROG)) u_tew_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .slave_addr_i(sa),
        .unlock_i(unlock), .mode_i(mode), .trim_o(trim_o), .addr_counter_o(addr_counter_o),
        .prog_busy_o(prog_busy_o));
    tew_host_model u_tew_host_model (.clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl),
        .sda_o(sda_h), .unlock_o(unlock), .mode_o(mode));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // expected analog trim view of words 62h..64h
    function automatic logic [21:0] exp_trim();
        logic [7:0] t, r, d;
        t = 8'(mem['h62]);
        r = 8'(mem['h63]);
        d = 8'(mem['h64]);
        return {t[5:0], r, d};
    endfunction : exp_trim
    // one byte-write transfer, then the reference model decides what must change
    task automatic do_write(input logic [6:0] a7, input logic [7:0] wa, input logic [7:0] d);
        logic ok;
        int   i;
        u_tew_host_model.write_word(a7, wa, d, extra, acks);
        check(acks, (a7 == sa) ? 4'he : 4'h0);
        ok = a7 == sa && unlock == tew_pkg::UNLOCK_KEY && mode == tew_pkg::MODE_EEPROM
             && wa >= tew_pkg::ADDR_FIRST && wa <= tew_pkg::ADDR_LAST;
        if (ok) begin
            mem[wa] = d;
            exp_cnt = (wa == tew_pkg::ADDR_LAST) ? 'h62 : wa + 1;
        end
        for (i = 0; i < 10 && prog_busy_o !== 1'b1; i++) @(negedge clk_i);
        check(prog_busy_o, ok);
        // host stays off the bus until programming is over
        for (i = 0; i < PROG + 10 && prog_busy_o !== 1'b0; i++) @(negedge clk_i);
        if (prog_busy_o !== 1'b0) begin
            n_errors++;
            end_of_test();
        end
        check(trim_o, exp_trim());
        check(addr_counter_o, exp_cnt);
        for (i = 0; i < tew_pkg::WORDS; i++) check(u_tew_top.mem[i], mem['h62 + i]);
    endtask : do_write
    initial begin
        reset_n_i = 1'b0;
        void'($urandom(3740));
        sa = 7'($urandom);
        for (int a = 'h62; a <= 'h68; a++) mem[a] = 0;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'b1;
        check(addr_counter_o, 'h62);
        check(trim_o, 0);
        check(prog_busy_o, 0);
        check(sda_o, 1'b0);
        u_tew_host_model.set_fields(tew_pkg::MODE_EEPROM, 5'h00);
        u_tew_host_model.idle(3000);
        do_write(sa, tew_pkg::ADDR_TEMP, 8'($urandom));  // locked: refused
        u_tew_host_model.set_fields(tew_pkg::MODE_EEPROM, tew_pkg::UNLOCK_KEY);
        for (int a = 'h62; a <= 'h68; a++) do_write(sa, 8'(a), 8'($urandom));
        // batch address, below the map, written here to show that it stores nothing
        do_write(sa, tew_pkg::ADDR_BATCH, 8'($urandom));
        do_write(sa, 8'h69, 8'($urandom));
        do_write(sa ^ 7'h01, tew_pkg::ADDR_REF, 8'($urandom));
        // random words across and around the map, some with a stray fourth byte
        repeat (8) begin
            extra = 1'($urandom);
            do_write(sa, 8'(8'h60 + $urandom_range(0, 10)), 8'($urandom));
        end
        extra = 1'b0;
        u_tew_host_model.set_fields(tew_pkg::MODE_PDOWN, tew_pkg::UNLOCK_KEY);
        do_write(sa, tew_pkg::ADDR_DRIVE, 8'($urandom));  // wrong mode: refused
        u_tew_host_model.set_fields(tew_pkg::MODE_PDOWN, 5'h00);
        end_of_test();
    end
endmodule : trim_eeprom_byte_write_map_bench
